// ===== src/bcc_consts.vh
// Constants for the bus command controller: codes and timing counts
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH

// ============================================================
// Cycle status codes (active-low lines read as a 3-bit value)
`define BCC_ST_IRQ_ACK 3'h0
`define BCC_ST_IO_RD 3'h1
`define BCC_ST_IO_WR 3'h2
`define BCC_ST_HALT 3'h3
`define BCC_ST_CODE 3'h4
`define BCC_ST_MEM_RD 3'h5
`define BCC_ST_MEM_WR 3'h6
`define BCC_ST_PASSIVE 3'h7

// ============================================================
// Sequencer state codes
`define BCC_S_IDLE 3'h0
`define BCC_S_STROBE 3'h1
`define BCC_S_ADDR 3'h2
`define BCC_S_EARLY 3'h3
`define BCC_S_DATA 3'h4

// ============================================================
// Timing: system clock and grant-to-command delay
`define BCC_CLK_PERIOD_NS 8
`define BCC_GRANT_DELAY_NS 105
// Least time, so round up to whole cycles
`define BCC_GRANT_DELAY_CYC \
    ((`BCC_GRANT_DELAY_NS + `BCC_CLK_PERIOD_NS - 1) / `BCC_CLK_PERIOD_NS)
`define BCC_GRANT_CNT_W 5

// ============================================================
// Pin synchroniser width: cpu clock, 3 status, strap, grant, gate
`define BCC_PIN_W 7

`endif

// ===== src/bcc_pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module bcc_pin_sync #(
    parameter W = 7,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] pin_i,
    output reg [W-1:0] level_o
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    integer k;

    // ============================================================
    // Capture chain; only s2 reads the first stage
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
        end else begin
            meta_reg <= pin_i;
            s2_reg <= meta_reg;
            s3_reg <= s2_reg;
        end
    end

    // ============================================================
    // A bit changes only once stages two and three agree
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_o <= INIT;
        end else begin
            for (k = 0; k < W; k = k + 1) begin
                if (s2_reg[k] == s3_reg[k]) begin
                    level_o[k] <= s3_reg[k];
                end
            end
        end
    end

endmodule // bcc_pin_sync

// ===== src/bcc_controller.v
// Bus command controller: status decode, command strobes, bus control
`timescale 1ns/1ps
`include "bcc_consts.vh"

module bcc_controller #(
    parameter GRANT_DELAY_CYC = `BCC_GRANT_DELAY_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire cpu_clk_i,
    input wire cycle_status_bit0_i,
    input wire cycle_status_bit1_i,
    input wire cycle_status_bit2_i,
    input wire bus_mode_strap_i,
    input wire bus_grant_n_i,
    input wire command_gate_i,
    output reg address_latch_strobe_o,
    output reg transfer_direction_o,
    output reg transceiver_enable_o,
    output reg cascade_or_periph_enable_o,
    output reg mem_read_cmd_n_o,
    output reg mem_write_cmd_n_o,
    output reg early_mem_write_cmd_n_o,
    output reg io_read_cmd_n_o,
    output reg io_write_cmd_n_o,
    output reg early_io_write_cmd_n_o,
    output reg irq_ack_cmd_n_o,
    output reg mem_cmd_oe_o,
    output reg io_cmd_oe_o
);

    // ============================================================
    // Pin synchronisation
    wire [`BCC_PIN_W-1:0] pins_w;
    wire cpu_clk_w;
    wire [2:0] status_w;
    wire strap_w;
    wire grant_n_w;
    wire gate_w;

    bcc_pin_sync #(
        .W(`BCC_PIN_W),
        .INIT(7'h7f)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({command_gate_i, bus_grant_n_i, bus_mode_strap_i,
                cycle_status_bit2_i, cycle_status_bit1_i,
                cycle_status_bit0_i, cpu_clk_i}),
        .level_o(pins_w)
    );

    assign cpu_clk_w = pins_w[0];
    assign status_w = pins_w[3:1];
    assign strap_w = pins_w[4];
    assign grant_n_w = pins_w[5];
    assign gate_w = pins_w[6];

    // ============================================================
    // CPU clock edge detection on the filtered level
    reg cpu_clk_q_reg;
    wire cpu_fall_w;
    wire cpu_rise_w;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_clk_q_reg <= 1'b1;
        end else begin
            cpu_clk_q_reg <= cpu_clk_w;
        end
    end

    assign cpu_fall_w = cpu_clk_q_reg & ~cpu_clk_w;
    assign cpu_rise_w = ~cpu_clk_q_reg & cpu_clk_w;

    // ============================================================
    // Decode helpers used by sequencer and output stage
    function is_mem;
        input [2:0] st;
        begin
            is_mem = st[2] & (st != `BCC_ST_PASSIVE);
        end
    endfunction

    function is_io;
        input [2:0] st;
        begin
            is_io = (st == `BCC_ST_IO_RD) | (st == `BCC_ST_IO_WR)
                  | (st == `BCC_ST_IRQ_ACK);
        end
    endfunction

    function is_write;
        input [2:0] st;
        begin
            is_write = (st == `BCC_ST_IO_WR) | (st == `BCC_ST_MEM_WR);
        end
    endfunction

    // ============================================================
    // Grant qualification: grant must stay low the full delay
    reg [`BCC_GRANT_CNT_W-1:0] grant_cnt_reg;
    reg grant_ok_reg;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            grant_cnt_reg <= {`BCC_GRANT_CNT_W{1'b0}};
            grant_ok_reg <= 1'b0;
        end else if (grant_n_w) begin
            grant_cnt_reg <= {`BCC_GRANT_CNT_W{1'b0}};
            grant_ok_reg <= 1'b0;
        end else if (grant_cnt_reg <
                     GRANT_DELAY_CYC[`BCC_GRANT_CNT_W-1:0] - 5'h1) begin
            grant_cnt_reg <= grant_cnt_reg + 5'h1;
        end else begin
            grant_ok_reg <= 1'b1;
        end
    end

    // ============================================================
    // Machine cycle sequencer
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [2:0] cyc_reg;
    reg strobe_reg;
    reg early_reg;
    reg late_reg;
    reg dir_read_reg;
    reg data_reg;
    reg cascade_reg;
    reg ack_first_reg;
    wire status_active_w;

    assign status_active_w = (status_w != `BCC_ST_PASSIVE);

    // Next-state decode
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `BCC_S_IDLE: begin
                // Whichever comes last: clock low or status active
                if (status_active_w && (!cpu_clk_w || cpu_fall_w)) begin
                    state_next = `BCC_S_STROBE;
                end
            end
            `BCC_S_STROBE: begin
                if (cpu_rise_w) begin
                    state_next = `BCC_S_ADDR;
                end
            end
            `BCC_S_ADDR: begin
                if (cpu_fall_w) begin
                    state_next = `BCC_S_EARLY;
                end
            end
            `BCC_S_EARLY: begin
                if (cpu_fall_w) begin
                    state_next = `BCC_S_DATA;
                end
            end
            `BCC_S_DATA: begin
                if (!status_active_w && cpu_fall_w) begin
                    state_next = `BCC_S_IDLE;
                end
            end
            default: begin
                state_next = `BCC_S_IDLE;
            end
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= `BCC_S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Cycle flags; the strobe runs in halt cycles too
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_reg <= `BCC_ST_PASSIVE;
            strobe_reg <= 1'b0;
            early_reg <= 1'b0;
            late_reg <= 1'b0;
            dir_read_reg <= 1'b0;
            data_reg <= 1'b0;
            cascade_reg <= 1'b0;
            ack_first_reg <= 1'b1;
        end else begin
            case (state_reg)
                `BCC_S_IDLE: begin
                    if (state_next == `BCC_S_STROBE) begin
                        cyc_reg <= status_w;
                        strobe_reg <= 1'b1;
                        // Cascade only in first acknowledge cycle
                        cascade_reg <= ack_first_reg &&
                            (status_w == `BCC_ST_IRQ_ACK);
                    end
                end
                `BCC_S_STROBE: begin
                    if (cpu_rise_w) begin
                        strobe_reg <= 1'b0;
                        cascade_reg <= 1'b0;
                        // Reads turn transceivers inward early
                        dir_read_reg <= status_active_w &&
                            !is_write(cyc_reg) &&
                            (cyc_reg != `BCC_ST_HALT);
                        if (cyc_reg == `BCC_ST_IRQ_ACK) begin
                            ack_first_reg <= ~ack_first_reg;
                        end else begin
                            ack_first_reg <= 1'b1;
                        end
                    end
                end
                `BCC_S_ADDR: begin
                    if (cpu_fall_w) begin
                        // Reads, acknowledge, early writes together
                        early_reg <= 1'b1;
                        data_reg <= 1'b1;
                    end
                end
                `BCC_S_EARLY: begin
                    if (cpu_fall_w) begin
                        late_reg <= 1'b1;
                    end
                end
                `BCC_S_DATA: begin
                    if (state_next == `BCC_S_IDLE) begin
                        early_reg <= 1'b0;
                        late_reg <= 1'b0;
                        data_reg <= 1'b0;
                        dir_read_reg <= 1'b0;
                        cyc_reg <= `BCC_ST_PASSIVE;
                    end
                end
                default: begin
                    strobe_reg <= 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // Command qualification by mode, grant and gate
    wire mem_en_w;
    wire io_en_w;
    wire rd_w;
    wire wr_w;
    wire ew_w;

    // Memory always needs the grant; I/O only in system mode
    assign mem_en_w = gate_w & grant_ok_reg;
    assign io_en_w = gate_w & (strap_w | grant_ok_reg);
    assign rd_w = early_reg;
    assign wr_w = late_reg;
    assign ew_w = early_reg;

    // ============================================================
    // Registered outputs; commands are active low
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            address_latch_strobe_o <= 1'b0;
            transfer_direction_o <= 1'b1;
            transceiver_enable_o <= 1'b0;
            cascade_or_periph_enable_o <= 1'b1;
            mem_read_cmd_n_o <= 1'b1;
            mem_write_cmd_n_o <= 1'b1;
            early_mem_write_cmd_n_o <= 1'b1;
            io_read_cmd_n_o <= 1'b1;
            io_write_cmd_n_o <= 1'b1;
            early_io_write_cmd_n_o <= 1'b1;
            irq_ack_cmd_n_o <= 1'b1;
            mem_cmd_oe_o <= 1'b0;
            io_cmd_oe_o <= 1'b0;
        end else begin
            address_latch_strobe_o <= strobe_reg;
            transfer_direction_o <= ~dir_read_reg;
            // Memory floated while grant missing; I/O only in system mode
            mem_cmd_oe_o <= grant_ok_reg;
            io_cmd_oe_o <= strap_w | grant_ok_reg;
            mem_read_cmd_n_o <= ~(rd_w & mem_en_w &
                ((cyc_reg == `BCC_ST_MEM_RD) |
                 (cyc_reg == `BCC_ST_CODE)));
            early_mem_write_cmd_n_o <= ~(ew_w & mem_en_w &
                (cyc_reg == `BCC_ST_MEM_WR));
            mem_write_cmd_n_o <= ~(wr_w & mem_en_w &
                (cyc_reg == `BCC_ST_MEM_WR));
            io_read_cmd_n_o <= ~(rd_w & io_en_w &
                (cyc_reg == `BCC_ST_IO_RD));
            early_io_write_cmd_n_o <= ~(ew_w & io_en_w &
                (cyc_reg == `BCC_ST_IO_WR));
            io_write_cmd_n_o <= ~(wr_w & io_en_w &
                (cyc_reg == `BCC_ST_IO_WR));
            // Same window as an I/O read
            irq_ack_cmd_n_o <= ~(rd_w & io_en_w &
                (cyc_reg == `BCC_ST_IRQ_ACK));
            if (strap_w) begin
                // Shared-bus transceivers need the grant; memory only here
                transceiver_enable_o <= data_reg & mem_en_w &
                    is_mem(cyc_reg);
                cascade_or_periph_enable_o <= ~(data_reg & gate_w &
                    is_io(cyc_reg));
            end else begin
                transceiver_enable_o <= data_reg & mem_en_w &
                    (is_mem(cyc_reg) | is_io(cyc_reg));
                cascade_or_periph_enable_o <= cascade_reg;
            end
        end
    end

endmodule // bcc_controller

// ===== bench/bcc_controller_monitor.sv
// Port assertions for the bus command controller
`timescale 1ns/1ps
module bcc_controller_monitor #(
    parameter GRANT_DELAY_CYC = 14
) (
    input wire clk_i,
    input wire rst_i,
    input wire bus_mode_strap_i,
    input wire bus_grant_n_i,
    input wire command_gate_i,
    input wire transfer_direction_o,
    input wire transceiver_enable_o,
    input wire mem_read_cmd_n_o,
    input wire mem_write_cmd_n_o,
    input wire early_mem_write_cmd_n_o,
    input wire io_read_cmd_n_o,
    input wire io_write_cmd_n_o,
    input wire early_io_write_cmd_n_o,
    input wire irq_ack_cmd_n_o,
    input wire mem_cmd_oe_o,
    input wire io_cmd_oe_o
);
    // ========================================
    // Helpers
    reg [4:0] grant_cnt_reg;
    wire rd_n = mem_read_cmd_n_o & io_read_cmd_n_o & irq_ack_cmd_n_o;
    wire wr_n = mem_write_cmd_n_o & io_write_cmd_n_o;
    wire early_n = early_mem_write_cmd_n_o & early_io_write_cmd_n_o;
    wire mw_n = mem_write_cmd_n_o & early_mem_write_cmd_n_o;
    wire iw_n = io_write_cmd_n_o & early_io_write_cmd_n_o;

    // Raw grant age; raw leads the filtered level, so it bounds it
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            grant_cnt_reg <= 5'h00;
        else if (bus_grant_n_i)
            grant_cnt_reg <= 5'h00;
        else if (grant_cnt_reg != 5'h1f)
            grant_cnt_reg <= grant_cnt_reg + 5'h01;
    end

    // ========================================
    // Assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_grant_delay: assert property (
        $rose(mem_cmd_oe_o) |-> grant_cnt_reg >= GRANT_DELAY_CYC)
        else $error("memory commands driven before grant settled");
    a_mem_float: assert property (
        bus_grant_n_i [*8] |-> !mem_cmd_oe_o)
        else $error("memory commands driven without grant");
    a_io_float: assert property (
        (bus_grant_n_i && !bus_mode_strap_i) [*8] |-> !io_cmd_oe_o)
        else $error("io commands driven without grant");
    a_io_always: assert property (
        bus_mode_strap_i [*8] |-> io_cmd_oe_o)
        else $error("io commands floating in io bus mode");
    a_gate_quiet: assert property (
        (!command_gate_i) [*8] |-> rd_n && wr_n && early_n
        && !transceiver_enable_o)
        else $error("command active while gate low");
    a_one_cmd: assert property (
        $countones({~mem_read_cmd_n_o, ~io_read_cmd_n_o,
        ~irq_ack_cmd_n_o, ~mw_n, ~iw_n}) <= 1)
        else $error("two command kinds active together");
    a_mem_early: assert property (
        $fell(mem_write_cmd_n_o) |-> !early_mem_write_cmd_n_o
        && !$past(early_mem_write_cmd_n_o))
        else $error("memory write before early memory write");
    a_io_early: assert property (
        $fell(io_write_cmd_n_o) |-> !early_io_write_cmd_n_o
        && !$past(early_io_write_cmd_n_o))
        else $error("io write before early io write");
    a_read_dir: assert property (
        !rd_n |-> !transfer_direction_o)
        else $error("direction high during read");
    a_write_dir: assert property (
        !(wr_n & early_n) |-> transfer_direction_o)
        else $error("direction low during write");
    a_xcvr_cmd: assert property (
        $rose(transceiver_enable_o) |-> !(rd_n & early_n))
        else $error("transceiver enabled outside data phase");
endmodule // bcc_controller_monitor

bind bcc_controller bcc_controller_monitor #(
    .GRANT_DELAY_CYC(GRANT_DELAY_CYC)
) u_mon (
    .clk_i(clk_i), .rst_i(rst_i),
    .bus_mode_strap_i(bus_mode_strap_i),
    .bus_grant_n_i(bus_grant_n_i),
    .command_gate_i(command_gate_i),
    .transfer_direction_o(transfer_direction_o),
    .transceiver_enable_o(transceiver_enable_o),
    .mem_read_cmd_n_o(mem_read_cmd_n_o),
    .mem_write_cmd_n_o(mem_write_cmd_n_o),
    .early_mem_write_cmd_n_o(early_mem_write_cmd_n_o),
    .io_read_cmd_n_o(io_read_cmd_n_o),
    .io_write_cmd_n_o(io_write_cmd_n_o),
    .early_io_write_cmd_n_o(early_io_write_cmd_n_o),
    .irq_ack_cmd_n_o(irq_ack_cmd_n_o),
    .mem_cmd_oe_o(mem_cmd_oe_o),
    .io_cmd_oe_o(io_cmd_oe_o)
);

// ===== bench/bcc_cpu_model.sv
// Processor model: free-running cpu clock and one status cycle per start
`timescale 1ns/1ps
module bcc_cpu_model (
    input wire clk_i,
    input wire start_i,
    input wire [2:0] code_i,
    output reg cpu_clk_o = 1'b0,
    output reg [2:0] status_o = 3'h7,
    output reg busy_o = 1'b0
);
    reg [2:0] cnt = 3'h0;
    reg [2:0] ph = 3'h0;
    reg [2:0] code = 3'h7;

    // Status changes on the same clk_i edge as a cpu rise so it is stable at the fall
    always @(posedge clk_i) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) begin
            cpu_clk_o <= ~cpu_clk_o;
            if (!cpu_clk_o && busy_o) begin
                ph <= ph + 3'h1;
                if (ph == 3'h0)
                    status_o <= code;
                if (ph == 3'h3)
                    status_o <= 3'h7; // pull-ups bring lines passive
                if (ph == 3'h5)
                    busy_o <= 1'b0;
            end
        end
        if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            ph <= 3'h0;
            code <= code_i;
        end
    end
endmodule // bcc_cpu_model

// ===== bench/bcc_controller_bench.sv
// Self-checking bench for the bus command controller
`timescale 1ns/1ps
module bcc_controller_bench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg strap = 1'b0;
    reg grant_n = 1'b0;
    reg gate = 1'b1;
    reg start = 1'b0;
    reg [2:0] code = 3'h7;
    reg first_ack = 1'b1;
    reg [10:0] seen = 11'h000;
    reg [10:0] exp;
    reg [31:0] r;
    integer failures = 0;
    integer check_count = 0;
    integer i;
    wire cpu_clk, busy, ale, dir, xen, dual, moe, ioe;
    wire [2:0] st;
    wire [6:0] cmd_n; // mrd, mwr, amw, iord, iow, aiow, ack
    wire [6:0] act = ~cmd_n & {{3{moe}}, {4{ioe}}};
    wire dual_act = strap ? !dual : dual;

    bcc_cpu_model u_cpu (.clk_i(clk_i), .start_i(start), .code_i(code),
        .cpu_clk_o(cpu_clk), .status_o(st), .busy_o(busy));

    bcc_controller #(.GRANT_DELAY_CYC(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cpu_clk_i(cpu_clk),
        .cycle_status_bit0_i(st[0]), .cycle_status_bit1_i(st[1]),
        .cycle_status_bit2_i(st[2]), .bus_mode_strap_i(strap),
        .bus_grant_n_i(grant_n), .command_gate_i(gate),
        .address_latch_strobe_o(ale), .transfer_direction_o(dir),
        .transceiver_enable_o(xen), .cascade_or_periph_enable_o(dual),
        .mem_read_cmd_n_o(cmd_n[6]), .mem_write_cmd_n_o(cmd_n[5]),
        .early_mem_write_cmd_n_o(cmd_n[4]), .io_read_cmd_n_o(cmd_n[3]),
        .io_write_cmd_n_o(cmd_n[2]), .early_io_write_cmd_n_o(cmd_n[1]),
        .irq_ack_cmd_n_o(cmd_n[0]), .mem_cmd_oe_o(moe), .io_cmd_oe_o(ioe));

    // ========================================
    // Clock and per-cycle activity record
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (start)
            seen <= 11'h000;
        else if (busy)
            seen <= seen | {ale, !dir, dual_act, xen, act};
    end

    // Expected activity: strobe, dir low, dual pin, xcvr, commands
    function [10:0] f_expect(input [2:0] c, input s, input g_n,
        input en, input fa);
        reg mo, io;
        reg [6:0] k;
        begin
            mo = en && !g_n;
            io = en && (s || !g_n);
            k[6] = mo && (c == 3'h4 || c == 3'h5);
            k[5] = mo && c == 3'h6;
            k[4] = k[5];
            k[3] = io && c == 3'h1;
            k[2] = io && c == 3'h2;
            k[1] = k[2];
            k[0] = io && c == 3'h0;
            f_expect[6:0] = k;
            f_expect[7] = s ? |k[6:4] : |k;
            f_expect[8] = s ? |k[3:0] : (c == 3'h0 && fa);
            f_expect[9] = c == 3'h0 || c == 3'h1 || c[2:1] == 2'h2;
            f_expect[10] = c != 3'h7;
        end
    endfunction

    task check(input [8*6-1:0] name, input [10:0] got, input [10:0] want);
        begin
            check_count = check_count + 1;
            if (got !== want) begin
                failures = failures + 1;
                $display("ERROR %0s expected %h seen %h", name, want, got);
            end
        end
    endtask

    task setup(input s, input g_n, input en);
        begin
            strap = s;
            grant_n = g_n;
            gate = en;
            repeat (24) @(negedge clk_i);
        end
    endtask

    // One bus cycle; the processor model owns the status timing
    task run_cycle(input [2:0] c);
        integer n;
        begin
            code = c;
            start = 1'b1;
            @(negedge clk_i);
            start = 1'b0;
            n = 0;
            while (busy && n < 200) begin
                @(negedge clk_i);
                n = n + 1;
            end
            if (n >= 200)
                failures = failures + 1;
            exp = f_expect(c, strap, grant_n, gate, first_ack);
            check("cycle", seen, exp);
            check("idle", {2'h0, dir, cmd_n, xen},
                {2'h0, 1'b1, 7'h7f, 1'b0});
            if (c == 3'h0)
                first_ack = !first_ack;
            else if (c != 3'h7)
                first_ack = 1'b1;
        end
    endtask

    task stop_test;
        begin
            if (failures == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // Hang guard, far beyond the planned run
    initial begin
        #400000;
        failures = failures + 1;
        stop_test;
    end

    // ========================================
    // Main sequence
    initial begin
        r = $urandom(56);
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        setup(1'b0, 1'b0, 1'b1);
        // Every code; two acks back to back for cascade pairing
        for (i = 0; i < 9; i = i + 1)
            run_cycle(i == 0 ? 3'h0 : i[2:0] - 3'h1);
        setup(1'b1, 1'b1, 1'b1); // io bus, no grant
        for (i = 0; i < 7; i = i + 1)
            run_cycle(i[2:0]);
        setup(1'b0, 1'b1, 1'b1); // system bus, no grant
        for (i = 0; i < 7; i = i + 1)
            run_cycle(i[2:0]);
        setup(1'b0, 1'b0, 1'b0); // gate low
        for (i = 0; i < 7; i = i + 1)
            run_cycle(i[2:0]);
        for (i = 0; i < 24; i = i + 1) begin
            r = $urandom;
            setup(r[0], r[1], r[3:2] != 2'h0);
            run_cycle(r[6:4]);
        end
        stop_test;
    end
endmodule // bcc_controller_bench
